// [design/lcd_cmd_pkg.sv]
// Constants, opcodes and carrier types for the LCD driver command decoder
// Notes on behaviour
// - Display on/off command bit 0 shows (1) or blanks (0) the panel, memory kept
// - Start-line command loads a 5-bit line address 0..1F for the first common row
// - Page-set command loads a 2-bit page for host accesses, display unaffected
// - Command with top bit 0 loads a column address 0..79
// - Column auto-increment stops at 50 hex; page never changes from it
// - Status byte: bit7 busy, bit6 segment order, bit5 display off, bit4 init, rest 0
// - Busy reads 1 during any operation or reset cycle; host waits for 0
// - Segment-order flag is 1 for column n to segment n, 0 for 79-n
// - Display state bit reads 0 when on and 1 when off
// - Data write stores the byte at page and column, then column plus one
// - Data read returns the byte at page and column; increments only outside RMW
// - Segment-direction command bit 0 picks normal or reversed column order
// - Static-drive bit 0 at 1 forces all commons active and the whole display on
// - Duty-select bit 0 gives 1/32 when 1 and 1/16 when 0
// - In RMW writes still increment, reads do not; column saved on entry
// - End command leaves RMW and restores the saved column address
// - Reset command sets start line 0 and page 3, memory kept, no pin reset
// - Display off plus static on gives power save; display on or static off exits
// - Reset pin level high selects 68-style strobes, low selects 80-style
// - Register select and direction decode data read, data write, status, command
// - Transfers go through a holding latch; reads return the prefetched byte
// - Pin reset: blank, line 0, static off, column 0, page 3, 1/32, RMW off
package lcd_cmd_pkg;

  // ----------------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------------
  localparam int NUM_COLS = 80;
  localparam int NUM_PAGES = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [6:0] COL_LIMIT = 7'h50;
  localparam logic [6:0] COL_LAST = 7'h4f;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] PAGE_RESET = 2'h3;
  localparam logic [4:0] LINE_RESET = 5'h00;
  localparam logic [6:0] COL_RESET = 7'h00;

  // ----------------------------------------------------------------------
  // Command opcodes (bit 0 masked where it carries data)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_DISPLAY = 8'hae;
  localparam logic [7:0] OP_ADC = 8'ha0;
  localparam logic [7:0] OP_STATIC = 8'ha4;
  localparam logic [7:0] OP_DUTY = 8'ha8;
  localparam logic [7:0] OP_RMW = 8'he0;
  localparam logic [7:0] OP_END = 8'hee;
  localparam logic [7:0] OP_RESET = 8'he2;
  localparam logic [7:0] OP_PAGE = 8'hb8;
  localparam logic [7:0] MASK_BIT0 = 8'hfe;
  localparam logic [7:0] MASK_PAGE = 8'hfc;
  localparam logic [7:0] MASK_LINE = 8'he0;
  localparam logic [7:0] OP_LINE = 8'hc0;

  // ----------------------------------------------------------------------
  // Status byte field positions
  // ----------------------------------------------------------------------
  localparam int ST_BUSY = 7;
  localparam int ST_SEG = 6;
  localparam int ST_OFF = 5;
  localparam int ST_INIT = 4;

  // One host write held between bus and executor
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } host_word_t;

endpackage : lcd_cmd_pkg

// [design/lcd_driver_command_decoder.sv]
// Host bus front end, write FIFO and command executor of the LCD driver
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------------
// Simple synchronous FIFO
// --------------------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : word_fifo

// --------------------------------------------------------------------------
// Command decoder top
// --------------------------------------------------------------------------
module lcd_driver_command_decoder #(
  parameter int NUM_COLS = lcd_cmd_pkg::NUM_COLS,
  parameter int NUM_PAGES = lcd_cmd_pkg::NUM_PAGES,
  parameter int FIFO_DEPTH = lcd_cmd_pkg::FIFO_DEPTH,
  parameter int INIT_CYCLES = lcd_cmd_pkg::INIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin,
  input wire logic register_select,
  input wire logic bus_strobe,
  input wire logic bus_dir,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out_q,
  output logic data_oe_q,
  output logic panel_on_q,
  output logic static_drive_q,
  output logic duty_32_q,
  output logic seg_normal_q,
  output logic [4:0] first_common_row_q,
  output logic power_save_q,
  output logic drivers_enable_q,
  output logic oscillator_pin_run_q
);
  localparam int RAM_WORDS = NUM_COLS * NUM_PAGES;

  // ------------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------------
  logic [7:0] ram [0:RAM_WORDS-1];
  logic pin_q;
  logic pin_prev_q;
  logic read_act_q;
  logic write_act_q;
  logic rs_q;
  logic [7:0] data_q;
  logic [7:0] read_latch_q;
  logic [6:0] col_q;
  logic [6:0] col_saved_q;
  logic rmw_q;
  logic [1:0] page_q;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_q;

  logic pin_edge;
  logic read_act;
  logic write_act;
  logic write_end;
  logic read_start;
  logic data_read_end;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic init_active;
  logic busy;
  logic [8:0] fifo_out_bits;
  logic [8:0] ram_addr;
  logic col_in_range;
  logic [7:0] status_byte;
  logic [7:0] cmd;
  logic cmd_valid;
  logic data_valid;
  lcd_cmd_pkg::host_word_t push_word;
  lcd_cmd_pkg::host_word_t pop_word;

  // ------------------------------------------------------------------------
  // Reset pin: level picks the bus style, any edge starts initialisation
  // ------------------------------------------------------------------------
  // Reset loads the live level, so no false edge or wrong bus style follows it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_q <= reset_pin;
      pin_prev_q <= reset_pin;
    end else begin
      pin_q <= reset_pin;
      pin_prev_q <= pin_q;
    end
  end
  assign pin_edge = pin_q ^ pin_prev_q;

  // Strobe decode: 68 style uses E plus R/W, 80 style active-low RD and WR
  assign read_act = pin_q ? (bus_strobe && bus_dir) : !bus_strobe;
  assign write_act = pin_q ? (bus_strobe && !bus_dir) : !bus_dir;

  // Bus sampling; data is taken while the strobe is still active
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      read_act_q <= 1'b0;
      write_act_q <= 1'b0;
      rs_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      read_act_q <= read_act;
      write_act_q <= write_act;
      if (read_act || write_act) begin
        rs_q <= register_select;
        data_q <= data_in;
      end
    end
  end

  // A write is committed when its strobe ends, a read starts on the leading edge
  assign write_end = write_act_q && !write_act;
  assign read_start = read_act && !read_act_q;
  assign data_read_end = read_act_q && !read_act && rs_q;

  // ------------------------------------------------------------------------
  // Holding FIFO between bus and executor
  // ------------------------------------------------------------------------
  assign push_word.is_data = rs_q;
  assign push_word.value = data_q;
  assign pop_word = lcd_cmd_pkg::host_word_t'(fifo_out_bits);

  // Draining stalls during initialisation, so a burst can really fill it
  assign init_active = (init_cnt_q != '0);
  assign fifo_pop = fifo_out_valid && !init_active;

  word_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_hold_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(write_end),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(!init_active),
    .out_data(fifo_out_bits)
  );

  assign cmd = pop_word.value;
  assign cmd_valid = fifo_pop && !pop_word.is_data;
  assign data_valid = fifo_pop && pop_word.is_data;

  // Busy covers pending work, a full holding FIFO and the init period
  assign busy = fifo_out_valid || !fifo_in_ready || init_active;

  // ------------------------------------------------------------------------
  // Initialisation period counter
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      init_cnt_q <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES);
    end else if (pin_edge) begin
      init_cnt_q <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES);
    end else if (cmd_valid && cmd == lcd_cmd_pkg::OP_RESET) begin
      init_cnt_q <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES);
    end else if (init_active) begin
      init_cnt_q <= init_cnt_q - 1'b1;
    end
  end

  // ------------------------------------------------------------------------
  // Display mode registers
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst || pin_edge) begin
      panel_on_q <= 1'b0;
      static_drive_q <= 1'b0;
      duty_32_q <= 1'b1;
      seg_normal_q <= 1'b1;
      first_common_row_q <= lcd_cmd_pkg::LINE_RESET;
    end else if (cmd_valid) begin
      if ((cmd & lcd_cmd_pkg::MASK_BIT0) == lcd_cmd_pkg::OP_DISPLAY) begin
        panel_on_q <= cmd[0];
      end
      if ((cmd & lcd_cmd_pkg::MASK_BIT0) == lcd_cmd_pkg::OP_STATIC) begin
        static_drive_q <= cmd[0];
      end
      if ((cmd & lcd_cmd_pkg::MASK_BIT0) == lcd_cmd_pkg::OP_DUTY) begin
        duty_32_q <= cmd[0];
      end
      if ((cmd & lcd_cmd_pkg::MASK_BIT0) == lcd_cmd_pkg::OP_ADC) begin
        seg_normal_q <= !cmd[0];
      end
      if ((cmd & lcd_cmd_pkg::MASK_LINE) == lcd_cmd_pkg::OP_LINE) begin
        first_common_row_q <= cmd[4:0];
      end
      if (cmd == lcd_cmd_pkg::OP_RESET) begin
        first_common_row_q <= lcd_cmd_pkg::LINE_RESET;
      end
    end
  end

  // Power save follows one cycle after the mode bits, in either order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      power_save_q <= 1'b0;
      drivers_enable_q <= 1'b0;
      oscillator_pin_run_q <= 1'b1;
    end else begin
      power_save_q <= !panel_on_q && static_drive_q;
      drivers_enable_q <= !(!panel_on_q && static_drive_q);
      oscillator_pin_run_q <= !(!panel_on_q && static_drive_q);
    end
  end

  // ------------------------------------------------------------------------
  // Page register; it only steers host accesses, never the display
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst || pin_edge) begin
      page_q <= lcd_cmd_pkg::PAGE_RESET;
    end else if (cmd_valid) begin
      if ((cmd & lcd_cmd_pkg::MASK_PAGE) == lcd_cmd_pkg::OP_PAGE) begin
        page_q <= cmd[1:0];
      end else if (cmd == lcd_cmd_pkg::OP_RESET) begin
        page_q <= lcd_cmd_pkg::PAGE_RESET;
      end
    end
  end

  // ------------------------------------------------------------------------
  // Column counter, read-modify-write mode and saved column
  // ------------------------------------------------------------------------
  // Reads never overlap executor pops in legal use, so the pop takes priority
  always_ff @(posedge clk_sys) begin
    if (srst || pin_edge) begin
      col_q <= lcd_cmd_pkg::COL_RESET;
      col_saved_q <= lcd_cmd_pkg::COL_RESET;
      rmw_q <= 1'b0;
    end else if (cmd_valid) begin
      if (!cmd[7]) begin
        if (cmd[6:0] <= lcd_cmd_pkg::COL_LAST) begin
          col_q <= cmd[6:0];
        end
      end else if (cmd == lcd_cmd_pkg::OP_RMW) begin
        rmw_q <= 1'b1;
        col_saved_q <= col_q;
      end else if (cmd == lcd_cmd_pkg::OP_END) begin
        rmw_q <= 1'b0;
        col_q <= col_saved_q;
      end
    end else if (data_valid) begin
      if (col_q != lcd_cmd_pkg::COL_LIMIT) begin
        col_q <= col_q + 7'h01;
      end
    end else if (data_read_end && !rmw_q) begin
      if (col_q != lcd_cmd_pkg::COL_LIMIT) begin
        col_q <= col_q + 7'h01;
      end
    end
  end

  // ------------------------------------------------------------------------
  // Display memory and read prefetch latch
  // ------------------------------------------------------------------------
  assign ram_addr = 9'(page_q) * 9'(NUM_COLS) + 9'(col_q);
  assign col_in_range = (col_q < lcd_cmd_pkg::COL_LIMIT);

  // Column 50 hex does not exist: writes there are dropped
  always_ff @(posedge clk_sys) begin
    if (data_valid && col_in_range) begin
      ram[ram_addr] <= cmd;
    end
  end

  // A read hands out the old latch and refills it from the current address,
  // which is why the first read after addressing returns stale data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      read_latch_q <= 8'h00;
    end else if (data_read_end) begin
      read_latch_q <= col_in_range ? ram[ram_addr] : 8'h00;
    end
  end

  // ------------------------------------------------------------------------
  // Read data output
  // ------------------------------------------------------------------------
  assign status_byte = {busy, seg_normal_q, !panel_on_q, init_active, 4'h0};

  // Data is launched on the first sampled cycle of the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_out_q <= 8'h00;
      data_oe_q <= 1'b0;
    end else begin
      data_oe_q <= read_act;
      if (read_start) begin
        data_out_q <= register_select ? read_latch_q : status_byte;
      end
    end
  end

endmodule : lcd_driver_command_decoder

`default_nettype wire

// [sim/lcd_driver_command_decoder_chk.sv]
// Port checker for the LCD command decoder, bound to its top
`timescale 1ns/1ns
`default_nettype none
// --------------------
// Checker
// --------------------
module lcd_dcd_chk #(
  parameter int INIT_CYCLES = 100
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin,
  input wire logic register_select,
  input wire logic bus_strobe,
  input wire logic bus_dir,
  input wire logic [7:0] data_out_q,
  input wire logic data_oe_q,
  input wire logic panel_on_q,
  input wire logic static_drive_q,
  input wire logic duty_32_q,
  input wire logic seg_normal_q,
  input wire logic [4:0] first_common_row_q,
  input wire logic power_save_q,
  input wire logic drivers_enable_q,
  input wire logic oscillator_pin_run_q
);
  logic rd_act;
  logic wr_act;
  logic [9:0] idle_q;
  // Strobe decode for both bus styles
  assign rd_act = reset_pin ? (bus_strobe & bus_dir) : ~bus_strobe;
  assign wr_act = reset_pin ? (bus_strobe & ~bus_dir) : ~bus_dir;
  // Cycles since the last write; the bound covers init plus a full FIFO drain
  always_ff @(posedge clk_sys) begin
    if (srst || wr_act) begin
      idle_q <= 10'h000;
    end else if (idle_q != 10'h3ff) begin
      idle_q <= idle_q + 10'h001;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  save_on_a: assert property (!panel_on_q && static_drive_q |=> power_save_q)
    else $error("power save not entered");
  save_off_a: assert property (panel_on_q || !static_drive_q |=> !power_save_q)
    else $error("power save not left");
  drv_stop_a: assert property (power_save_q [*2] |->
    !drivers_enable_q && !oscillator_pin_run_q)
    else $error("drivers run in power save");
  oe_on_a: assert property (rd_act |=> data_oe_q)
    else $error("read data not driven");
  out_hold_a: assert property ($changed(data_out_q) |->
    $past(rd_act) && !$past(data_oe_q))
    else $error("read data changed outside read start");
  status_fmt_a: assert property (rd_act && !register_select && !data_oe_q |=>
    data_out_q[3:0] == 4'h0 && data_out_q[6] == $past(seg_normal_q)
    && data_out_q[5] == !$past(panel_on_q))
    else $error("status byte malformed");
  rst_vals_a: assert property ($fell(srst) |->
    !panel_on_q && !static_drive_q && duty_32_q && seg_normal_q
    && first_common_row_q == 5'h00)
    else $error("reset values wrong");
  mode_hold_a: assert property (idle_q > INIT_CYCLES + 40 |->
    $stable({panel_on_q, static_drive_q, duty_32_q, seg_normal_q, first_common_row_q}))
    else $error("mode changed without a command");
endmodule : lcd_dcd_chk

bind lcd_driver_command_decoder lcd_dcd_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .reset_pin(reset_pin), .register_select(register_select),
  .bus_strobe(bus_strobe), .bus_dir(bus_dir), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
  .panel_on_q(panel_on_q), .static_drive_q(static_drive_q), .duty_32_q(duty_32_q),
  .seg_normal_q(seg_normal_q), .first_common_row_q(first_common_row_q),
  .power_save_q(power_save_q), .drivers_enable_q(drivers_enable_q),
  .oscillator_pin_run_q(oscillator_pin_run_q)
);
`default_nettype wire

// [sim/lcd_driver_command_decoder_tb_top.sv]
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ns
`default_nettype none
// --------------------
// Bench top
// --------------------
module lcd_driver_command_decoder_tb_top;
  localparam int INIT = 200;
  logic clk_sys, srst, reset_pin, register_select, bus_strobe, bus_dir, mode68;
  logic data_oe_q, panel_on_q, static_drive_q, duty_32_q, seg_normal_q;
  logic power_save_q, drivers_enable_q, oscillator_pin_run_q, oe_prev, rmw;
  logic [7:0] data_in, data_out_q, v, lat;
  logic [4:0] first_common_row_q;
  logic [6:0] col_t, saved;
  logic [1:0] pg_t;
  logic [8:0] notes[$];
  logic [7:0] mem[4][80];
  logic [7:0] ps_cmd[6] = '{8'ha5, 8'hae, 8'haf, 8'hae, 8'ha4, 8'haf};
  logic [3:0] ps_exp[6] = '{4'hb, 4'hc, 4'hb, 4'hc, 4'h3, 4'h3};
  logic [4:0] lines[4] = '{5'h00, 5'h01, 5'h1e, 5'h1f};
  logic [7:0] odd_cmd[3] = '{8'hff, 8'hb0, 8'he4};
  integer seed = 33793;
  int fails = 0;
  int samples_checked = 0;

  lcd_driver_command_decoder #(.INIT_CYCLES(INIT)) dut (
    .clk_sys(clk_sys), .srst(srst), .reset_pin(reset_pin), .register_select(register_select),
    .bus_strobe(bus_strobe), .bus_dir(bus_dir), .data_in(data_in), .data_out_q(data_out_q),
    .data_oe_q(data_oe_q), .panel_on_q(panel_on_q), .static_drive_q(static_drive_q),
    .duty_32_q(duty_32_q), .seg_normal_q(seg_normal_q), .first_common_row_q(first_common_row_q),
    .power_save_q(power_save_q), .drivers_enable_q(drivers_enable_q),
    .oscillator_pin_run_q(oscillator_pin_run_q)
  );
  lcd_host_model host (
    .clk_sys(clk_sys), .mode68(mode68), .rd_data(data_out_q), .register_select(register_select),
    .bus_strobe(bus_strobe), .bus_dir(bus_dir), .data_in(data_in)
  );

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // A read notes its expectation; the watcher compares when the byte appears
  task automatic rd(input logic rs, input logic [7:0] exp, input logic chk);
    notes.push_back({chk, exp});
    host.read(rs, v);
  endtask : rd
  // Only status reads go out while busy
  task automatic wait_ready();
    int n = 0;
    v = 8'hff;
    while (v[7] !== 1'b0 && n < 300) begin
      rd(1'b0, 8'h00, 1'b0);
      n++;
    end
    if (n == 300) fails++;
  endtask : wait_ready
  task automatic xfer(input logic rs, input logic [7:0] b);
    wait_ready();
    host.write(rs, b);
    wait_ready();
  endtask : xfer
  // Column set is only issued outside read-modify-write
  task automatic set_pos(input logic [1:0] p, input logic [6:0] c);
    xfer(1'b0, {6'h2e, p});
    xfer(1'b0, {1'b0, c});
    pg_t = p;
    col_t = c;
  endtask : set_pos
  task automatic wr(input logic [7:0] b);
    xfer(1'b1, b);
    if (col_t < 7'h50) begin
      mem[pg_t][col_t] = b;
      col_t++;
    end
  endtask : wr
  // Each data read returns the previous prefetch and prefetches the current column
  task automatic rdd(input logic chk);
    rd(1'b1, lat, chk);
    lat = (col_t < 7'h50) ? mem[pg_t][col_t] : 8'h00;
    if (!rmw && col_t < 7'h50) col_t++;
  endtask : rdd
  task automatic modes(input logic [8:0] exp);
    check({3'h0, first_common_row_q}, {3'h0, exp[4:0]});
    check({4'h0, panel_on_q, static_drive_q, duty_32_q, seg_normal_q}, {4'h0, exp[8:5]});
  endtask : modes

  // Read watcher, sampling after the edge has settled
  initial begin
    logic [8:0] nt;
    oe_prev = 1'b0;
    forever begin
      @(posedge clk_sys);
      #2;
      if (data_oe_q === 1'b1 && oe_prev !== 1'b1) begin
        if (notes.size() == 0) begin
          fails++;
        end else begin
          nt = notes.pop_front();
          if (nt[8]) check(data_out_q, nt[7:0]);
        end
      end
      oe_prev = data_oe_q;
    end
  end

  // Watchdog against a hang
  initial begin
    #200000;
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    reset_pin = 1'b1;
    mode68 = 1'b1;
    rmw = 1'b0;
    lat = 8'h00;
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(1'b0, 8'hf0, 1'b1);
    wait_ready();
    rd(1'b0, 8'h60, 1'b1);
    modes(9'h060);
    xfer(1'b0, 8'haf);
    rd(1'b0, 8'h40, 1'b1);
    xfer(1'b0, 8'ha1);
    rd(1'b0, 8'h00, 1'b1);
    xfer(1'b0, 8'ha8);
    modes(9'h100);
    xfer(1'b0, 8'ha9);
    xfer(1'b0, 8'ha0);
    modes(9'h160);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, ps_cmd[i]);
      check({4'h0, static_drive_q, power_save_q, drivers_enable_q, oscillator_pin_run_q},
        {4'h0, ps_exp[i]});
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, {3'h6, lines[i]});
      check({3'h0, first_common_row_q}, {3'h0, lines[i]});
    end
    for (int p = 0; p < 4; p += 3) begin
      set_pos(p[1:0], 7'h00);
      repeat (40) wr(8'($random(seed)));
      set_pos(p[1:0], 7'h00);
      rdd(1'b0);
      repeat (40) rdd(1'b1);
    end
    modes(9'h17f);
    set_pos(2'h0, 7'h4e);
    xfer(1'b0, 8'h50);
    repeat (3) wr(8'($random(seed)));
    set_pos(2'h0, 7'h4e);
    rdd(1'b0);
    repeat (4) rdd(1'b1);
    set_pos(2'h0, 7'h0a);
    xfer(1'b0, 8'he0);
    rmw = 1'b1;
    saved = col_t;
    rdd(1'b0);
    repeat (2) rdd(1'b1);
    repeat (2) wr(8'($random(seed)));
    xfer(1'b0, 8'hee);
    rmw = 1'b0;
    col_t = saved;
    rdd(1'b0);
    repeat (2) rdd(1'b1);
    xfer(1'b0, 8'he2);
    pg_t = 2'h3;
    modes(9'h160);
    xfer(1'b0, 8'h05);
    col_t = 7'h05;
    rdd(1'b0);
    rdd(1'b1);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, odd_cmd[i]);
      modes(9'h160);
    end
    // Second reset into the 80-style bus, then flood the FIFO past its depth
    srst = 1'b1;
    reset_pin = 1'b0;
    mode68 = 1'b0;
    host.idle();
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i < 40; i++) begin
      v = 8'($random(seed));
      host.write(1'b1, v);
      if (i < 32) mem[3][i] = v;
    end
    wait_ready();
    modes(9'h060);
    set_pos(2'h3, 7'h00);
    rdd(1'b0);
    repeat (40) rdd(1'b1);
    // Long quiet spell so the checker's mode-hold watch really arms
    repeat (260) @(posedge clk_sys);
    conclude();
  end
endmodule : lcd_driver_command_decoder_tb_top
`default_nettype wire

// [sim/lcd_host_model.sv]
// Host processor model for the LCD decoder parallel bus, both bus styles
`timescale 1ns/1ns
`default_nettype none
// --------------------
// Host model
// --------------------
module lcd_host_model (
  input wire logic clk_sys,
  input wire logic mode68,
  input wire logic [7:0] rd_data,
  output logic register_select,
  output logic bus_strobe,
  output logic bus_dir,
  output logic [7:0] data_in
);
  // Idle levels of the 68-style bus at time zero
  initial begin
    register_select = 1'b0;
    bus_strobe = 1'b0;
    bus_dir = 1'b1;
    data_in = 8'h00;
  end
  // 68 style: enable plus direction; 80 style: separate low strobes
  task automatic drive(input logic act, input logic rd);
    bus_strobe = mode68 ? act : ~(act & rd);
    bus_dir = mode68 ? (rd | ~act) : ~(act & ~rd);
  endtask : drive
  // Released data lines flip, so a stale byte never looks valid
  task automatic idle();
    drive(1'b0, 1'b0);
    data_in = ~data_in;
  endtask : idle
  // Strobe held two cycles; read data taken at the closing edge, then released
  task automatic access(input logic rs, input logic rd, input logic [7:0] b,
      output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    register_select = rs;
    data_in = b;
    drive(1'b1, rd);
    repeat (2) @(posedge clk_sys);
    q = rd_data;
    #1;
    idle();
  endtask : access
  task automatic write(input logic rs, input logic [7:0] b);
    logic [7:0] q;
    access(rs, 1'b0, b, q);
  endtask : write
  task automatic read(input logic rs, output logic [7:0] q);
    access(rs, 1'b1, ~data_in, q);
  endtask : read
endmodule : lcd_host_model
`default_nettype wire
